/* File: hw/fms_params.svh */
/*
 Constants of the float mode slot sequencer: codes, widths, timing counts.
 Assumes inclusion by the package and by the sequencer module.
*/
// Function
// - Alternate photodiode and external ECG measurements on consecutive slots.
// - Each slot result readable from the buffer or per-slot data registers.
// - Float mode routes through TIA and integrator, filter bypassed.
// - Whole charge dump lies in negative phase; positive phase cancels offsets.
// - Precondition keeps photodiode on the TIA, integrator off.
// - Reference code 0x2 selects 0.9 V, programmed by host for float.
// - Cathode override with cathode code 0x2 gives about 250 mV bias.
// - Float start disconnects photodiode and isolates TIA input.
// - Integrator resets to zero just before the positive phase.
// - Synchronous LED pulse fires between float start and reconnection.
// - Positive integration starts while the photodiode still floats.
// - Negative phase begins before the photodiode is reconnected.
// - Photodiode reconnects during the negative phase to dump charge.
// - After the dump the TIA disconnects; negative phase completes.
// - Integrator output held after negative phase until ADC samples.
// - Emitter select zero enables float operation for the slot.
// - Float enable value 3 enables floating between connect pulses.
`ifndef FMS_PARAMS_SVH
`define FMS_PARAMS_SVH

`define FMS_CLK_MHZ        200
`define FMS_FLOAT_MIN_NS   4000
`define FMS_FLOAT_MIN_CYC  ((`FMS_FLOAT_MIN_NS * `FMS_CLK_MHZ + 999) / 1000)
`define FMS_CNT_W          18
`define FMS_DATA_W         20
`define FMS_EMIT_FLOAT     2'h0
`define FMS_FLT_EN_ON      2'h3
`define FMS_VREF_0V9       2'h2
`define FMS_VCAT_BIAS      2'h2
`define FMS_AMB_PULSES     8'h02
`define FMS_BUF_DEPTH      2

`endif

/* File: hw/fms_pkg.sv */
/*
 Types of the float mode slot sequencer.
 Assumes fms_params.svh is on the include path.
*/
`include "fms_params.svh"
package fms_pkg;

   typedef enum logic [3:0] {
      FMS_IDLE   = 4'h0,
      FMS_PRECON = 4'h1,
      FMS_FLOAT  = 4'h3,
      FMS_IRST   = 4'h2,
      FMS_POS    = 4'h6,
      FMS_NEGF   = 4'h7,
      FMS_DUMP   = 4'h5,
      FMS_TAIL   = 4'h4,
      FMS_HOLD   = 4'hc
   } fms_state_t;

   typedef struct packed {
      logic [1:0] slot_emitter_select;
      logic [1:0] slot_float_enable;
      logic [7:0] slot_pulse_count;
      logic [1:0] tia_reference_level;
      logic       cathode_override;
      logic [1:0] cathode_level;
      logic       sync_led;
      logic [4:0] precon_us;
      logic [9:0] float1_us;
      logic [9:0] float2_us;
      logic [4:0] pos_us;
      logic [4:0] negf_us;
      logic [4:0] conn_us;
      logic [4:0] tail_us;
   } fms_cfg_t;

   typedef struct packed {
      logic pd_connect;
      logic tia_connect;
      logic bpf_bypass;
      logic int_reset;
      logic int_pos;
      logic int_neg;
      logic int_hold;
      logic led_pulse;
      logic cathode_bias;
      logic tia_adc_mode;
      logic external_current_input_one;
   } fms_ctl_t;

   typedef struct packed {
      logic                   slot_b;
      logic [7:0]             pulse;
      logic [`FMS_DATA_W-1:0] data;
   } fms_res_t;

endpackage

/* File: hw/fms_buf.sv */
/*
 Small result buffer with valid/ready on both sides.
 Assumes one clock; the drain side may stall at will.
*/
`timescale 1ns/1ps
module fms_buf #(
   parameter int W     = 29,
   parameter int DEPTH = 2
) (
   input  wire logic         clk,       // Clock
   input  wire logic         rst_b,     // Async reset, low
   input  wire logic         in_valid,  // Word offered
   output logic              in_ready,  // Space free
   input  wire logic [W-1:0] in_data,   // Word in
   output logic              out_valid, // Word waiting
   input  wire logic         out_ready, // Drain takes word
   output logic [W-1:0]      out_data   // Oldest word
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("fms_buf: DEPTH must be a power of two, at least 2");
   end

   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wr_q, wr_d, rd_q, rd_d;
   logic         push, pop;

   always_comb begin
      in_ready  = (wr_q - rd_q) != (AW + 1)'(DEPTH);
      out_valid = wr_q != rd_q;
      out_data  = mem_q[rd_q[AW-1:0]];
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      wr_d      = push ? wr_q + 1'b1 : wr_q;
      rd_d      = pop ? rd_q + 1'b1 : rd_q;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule

/* File: hw/fms_seq.sv */
/*
 Float mode slot sequencer: runs slots A and B in turn, each float slot as a train of
 pulses through precondition, float, integrator reset, positive and
 negative phases, charge dump, TIA disconnect and hold for the ADC.
 Assumes the ADC and slot trigger live on clk; analog switches follow ctl.
*/
`timescale 1ns/1ps
`include "fms_params.svh"
module fms_seq #(
   parameter int CLK_MHZ = `FMS_CLK_MHZ,
   parameter int DATA_W  = `FMS_DATA_W,
   parameter int DEPTH   = `FMS_BUF_DEPTH
) (
   input  wire logic                clk,          // 200 MHz clock
   input  wire logic                rst_b,        // Async reset, low
   input  wire fms_pkg::fms_cfg_t   cfg_a,        // Slot A setup
   input  wire fms_pkg::fms_cfg_t   cfg_b,        // Slot B setup
   input  wire logic                ecg_sync,     // Slot B takes ECG input
   input  wire logic                slot_trig,    // Start next slot
   input  wire logic                adc_valid,    // ADC sample ready
   input  wire logic [DATA_W-1:0]   adc_data,     // ADC sample
   output logic                     adc_req,      // Hold, sample now
   output fms_pkg::fms_ctl_t        ctl,          // Switch controls
   output logic                     busy,         // Slot running
   output logic                     slot_b_now,   // Current slot is B
   output logic                     slot_done,    // Slot finished
   output logic                     cfg_err,      // Float too short
   output logic                     cfg_warn,     // Float setup unusual
   output logic [DATA_W-1:0]        slot_a_data,  // Last slot A result
   output logic [DATA_W-1:0]        slot_b_data,  // Last slot B result
   output logic                     res_valid,    // Buffered result
   input  wire logic                res_ready,    // Reader takes result
   output fms_pkg::fms_res_t        res           // Result word
);
   localparam int CW = `FMS_CNT_W;

   if (CLK_MHZ < 1 || DATA_W != `FMS_DATA_W || DEPTH < 2) begin : g_chk
      $error("fms_seq: unsupported parameter values");
   end

   localparam logic [CW-1:0] FLOAT_MIN = CW'(`FMS_FLOAT_MIN_CYC);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Microseconds to cycles, at least one cycle
   function automatic logic [CW-1:0] us2cyc(input logic [9:0] us);
      logic [CW-1:0] c;
      c = CW'(us * CLK_MHZ);
      return (c == '0) ? CW'(1) : c;
   endfunction

   // Counter load for a phase of n cycles
   function automatic logic [CW-1:0] ld(input logic [CW-1:0] n);
      return n - CW'(1);
   endfunction

   // Float long enough, with room for reset, positive and early negative
   function automatic logic flt_ok(input logic [CW-1:0] f,
                                   input logic [CW-1:0] p,
                                   input logic [CW-1:0] n);
      return f >= FLOAT_MIN && f > p + n + CW'(1);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Slot decode

   fms_pkg::fms_state_t  st_q, st_d;
   logic [CW-1:0]        cnt_q, cnt_d;
   logic [7:0]           pls_q, pls_d;
   logic                 slb_q, slb_d;
   logic                 err_q, err_d;
   logic                 done_q, done_d;
   logic [DATA_W-1:0]    da_q, da_d, db_q, db_d;
   fms_pkg::fms_ctl_t    ctl_q, ctl_d;
   fms_pkg::fms_cfg_t    cf;
   logic                 fmode, ecg, valid, zero, last;
   logic [CW-1:0]        flt, pre_f, pos, negf, conn, tail, prec;
   logic [7:0]           npls;
   logic                 buf_ready, push;
   fms_pkg::fms_res_t    push_w;

   always_comb begin
      cf    = slb_q ? cfg_b : cfg_a;
      ecg   = ecg_sync && slb_q;
      fmode = !ecg && cf.slot_emitter_select == `FMS_EMIT_FLOAT
              && cf.slot_float_enable == `FMS_FLT_EN_ON;
      flt   = us2cyc(pls_q == 8'h00 ? cf.float1_us : cf.float2_us);
      prec  = us2cyc({5'h00, cf.precon_us});
      pos   = us2cyc({5'h00, cf.pos_us});
      negf  = us2cyc({5'h00, cf.negf_us});
      conn  = us2cyc({5'h00, cf.conn_us});
      tail  = us2cyc({5'h00, cf.tail_us});
      // Float window A..D holds reset, positive and early negative
      pre_f = flt - pos - negf - CW'(1);
      npls  = (cf.slot_pulse_count == 8'h00) ? 8'h01 : cf.slot_pulse_count;
      // short float refused, first and later pulses
      valid = flt_ok(us2cyc(cf.float1_us), pos, negf)
              && (npls == 8'h01
                  || flt_ok(us2cyc(cf.float2_us), pos, negf));
      last  = (pls_q + 8'h01) >= npls;
      zero  = cnt_q == '0;
   end

   // Host setup checks for float and ECG slots
   always_comb begin
      cfg_warn = 1'b0;
      if (fmode && (cf.tia_reference_level != `FMS_VREF_0V9
                    || !cf.cathode_override
                    || cf.cathode_level != `FMS_VCAT_BIAS
                    || (!cf.sync_led
                        && cf.slot_pulse_count != `FMS_AMB_PULSES))) begin
         cfg_warn = 1'b1;
      end
      if (ecg && cf.tia_reference_level != `FMS_VREF_0V9) begin
         cfg_warn = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequence

   always_comb begin
      st_d   = st_q;
      cnt_d  = zero ? cnt_q : cnt_q - CW'(1);
      pls_d  = pls_q;
      slb_d  = slb_q;
      err_d  = err_q;
      done_d = 1'b0;
      da_d   = da_q;
      db_d   = db_q;
      push   = 1'b0;
      unique case (st_q)
         fms_pkg::FMS_IDLE: begin
            if (slot_trig) begin
               err_d = fmode && !valid;
               if (fmode && !valid) begin
                  slb_d  = !slb_q;
                  done_d = 1'b1;
               end else begin
                  pls_d = 8'h00;
                  st_d  = fms_pkg::FMS_PRECON;
                  cnt_d = ld(ecg ? conn : prec);
               end
            end
         end
         fms_pkg::FMS_PRECON: begin
            if (zero) begin
               if (ecg) begin
                  st_d = fms_pkg::FMS_HOLD;
               end else if (fmode) begin
                  st_d  = fms_pkg::FMS_FLOAT;
                  cnt_d = ld(pre_f);
               end else begin
                  st_d  = fms_pkg::FMS_DUMP;
                  cnt_d = ld(conn);
               end
            end
         end
         fms_pkg::FMS_FLOAT: begin
            if (zero) begin
               st_d = fms_pkg::FMS_IRST;
            end
         end
         fms_pkg::FMS_IRST: begin
            st_d  = fms_pkg::FMS_POS;
            cnt_d = ld(pos);
         end
         fms_pkg::FMS_POS: begin
            if (zero) begin
               st_d  = fms_pkg::FMS_NEGF;
               cnt_d = ld(negf);
            end
         end
         fms_pkg::FMS_NEGF: begin
            if (zero) begin
               st_d  = fms_pkg::FMS_DUMP;
               cnt_d = ld(conn);
            end
         end
         fms_pkg::FMS_DUMP: begin
            if (zero) begin
               if (fmode) begin
                  st_d  = fms_pkg::FMS_TAIL;
                  cnt_d = ld(tail);
               end else begin
                  st_d = fms_pkg::FMS_HOLD;
               end
            end
         end
         fms_pkg::FMS_TAIL: begin
            if (zero) begin
               st_d = fms_pkg::FMS_HOLD;
            end
         end
         fms_pkg::FMS_HOLD: begin
            if (adc_valid && buf_ready) begin
               push = 1'b1;
               if (slb_q) begin
                  db_d = adc_data;
               end else begin
                  da_d = adc_data;
               end
               pls_d = pls_q + 8'h01;
               if (last) begin
                  st_d   = fms_pkg::FMS_IDLE;
                  slb_d  = !slb_q;
                  done_d = 1'b1;
               end else begin
                  st_d  = fms_pkg::FMS_PRECON;
                  cnt_d = ld(prec);
               end
            end
         end
         default: begin
            st_d = fms_pkg::FMS_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Switch decode, registered from next state

   always_comb begin
      ctl_d = '0;
      if (st_d != fms_pkg::FMS_IDLE) begin
         ctl_d.pd_connect = !fmode || st_d == fms_pkg::FMS_PRECON
                            || st_d == fms_pkg::FMS_DUMP;
         ctl_d.tia_connect = ctl_d.pd_connect;
         ctl_d.bpf_bypass = fmode || ecg;
         ctl_d.tia_adc_mode = ecg;
         ctl_d.external_current_input_one = ecg;
         ctl_d.int_reset = st_d == fms_pkg::FMS_IRST;
         ctl_d.int_pos = st_d == fms_pkg::FMS_POS;
         ctl_d.int_neg = st_d == fms_pkg::FMS_NEGF
                         || (fmode && st_d == fms_pkg::FMS_DUMP)
                         || st_d == fms_pkg::FMS_TAIL;
         ctl_d.int_hold = st_d == fms_pkg::FMS_HOLD;
         ctl_d.led_pulse = fmode
            ? cf.sync_led && (st_d == fms_pkg::FMS_FLOAT
                              || st_d == fms_pkg::FMS_IRST
                              || st_d == fms_pkg::FMS_POS
                              || st_d == fms_pkg::FMS_NEGF)
            : !ecg && st_d == fms_pkg::FMS_DUMP;
         ctl_d.cathode_bias = st_d == fms_pkg::FMS_PRECON
                              && cf.cathode_override
                              && cf.cathode_level == `FMS_VCAT_BIAS;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q   <= fms_pkg::FMS_IDLE;
         cnt_q  <= '0;
         pls_q  <= 8'h00;
         slb_q  <= 1'b0;
         err_q  <= 1'b0;
         done_q <= 1'b0;
         da_q   <= '0;
         db_q   <= '0;
         ctl_q  <= '0;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         pls_q  <= pls_d;
         slb_q  <= slb_d;
         err_q  <= err_d;
         done_q <= done_d;
         da_q   <= da_d;
         db_q   <= db_d;
         ctl_q  <= ctl_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result buffer

   always_comb begin
      push_w.slot_b = slb_q;
      push_w.pulse  = pls_q;
      push_w.data   = adc_data;
   end

   fms_buf #(
      .W     ($bits(fms_pkg::fms_res_t)),
      .DEPTH (DEPTH)
   ) u_buf (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_valid  (push),
      .in_ready  (buf_ready),
      .in_data   (push_w),
      .out_valid (res_valid),
      .out_ready (res_ready),
      .out_data  (res)
   );

   always_comb begin
      adc_req     = st_q == fms_pkg::FMS_HOLD;
      ctl         = ctl_q;
      busy        = st_q != fms_pkg::FMS_IDLE;
      slot_b_now  = slb_q;
      slot_done   = done_q;
      cfg_err     = err_q;
      slot_a_data = da_q;
      slot_b_data = db_q;
   end
endmodule

/* File: dv/fms_sensor.sv */
/*
 Behavioural sensor and ADC source facing the slot sequencer.
 Assumes adc_req rises in the hold state and falls once a sample is taken.
*/
`timescale 1ns/1ps
module fms_sensor (
   input  wire logic  clk,        // Clock
   input  wire logic  rst_b,      // Async reset, low
   input  wire logic  adc_req,    // Sequencer waits for a sample
   input  wire logic  slow,       // Answer late
   output logic       adc_valid,  // Sample offered
   output logic [19:0] adc_data   // Sample value
);
   logic [19:0] n;
   logic [7:0]  w;

   ////////////////////////////////////////////////////////////////////////
   // Samples count up; between samples the data lines toggle every cycle
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         adc_valid <= 1'b0;
         adc_data  <= 20'h0_0000;
         n         <= 20'h0_0000;
         w         <= 8'h00;
      end else if (adc_valid && !adc_req) begin
         adc_valid <= 1'b0;
         adc_data  <= ~adc_data;
         n         <= n + 20'h0_0001;
      end else if (adc_req && !adc_valid && w >= (slow ? 8'h1e : 8'h00)) begin
         adc_valid <= 1'b1;
         adc_data  <= 20'h0_a000 + n;
         w         <= 8'h00;
      end else if (!adc_valid) begin
         adc_data <= ~adc_data;
         w        <= adc_req ? w + 8'h01 : 8'h00;
      end
   end
endmodule

/* File: dv/fms_seq_chk.sv */
/*
 Port checker of the float mode slot sequencer.
 Assumes it is bound to fms_seq and sees only its ports.
*/
`timescale 1ns/1ps
module fms_seq_chk (
   input  wire logic              clk,       // Clock
   input  wire logic              rst_b,     // Async reset, low
   input  wire fms_pkg::fms_ctl_t ctl,       // Switch controls
   input  wire logic              busy,      // Slot running
   input  wire logic              adc_req,   // Hold request
   input  wire logic              slot_done, // Slot end pulse
   input  wire logic              cfg_err,   // Refused slot
   input  wire logic              res_valid, // Buffered result
   input  wire logic              res_ready, // Reader takes
   input  wire fms_pkg::fms_res_t res        // Result word
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   ////////////////////////////////////////////////////////////////////////
   property p_precon;
      $rose(busy) |-> !ctl.int_pos && !ctl.int_neg
         && (ctl.pd_connect || ctl.tia_adc_mode);
   endproperty
   a_precon: assert property (p_precon)
      else $error("integrator active or diode open in precondition");
   property p_iso;
      ctl.int_reset |-> !ctl.pd_connect && !ctl.tia_connect;
   endproperty
   a_iso: assert property (p_iso)
      else $error("input not isolated while floating");
   property p_rst_pos;
      ctl.int_reset |=> ctl.int_pos && !ctl.int_reset;
   endproperty
   a_rst_pos: assert property (p_rst_pos)
      else $error("positive phase does not follow integrator reset");
   property p_bypass;
      (ctl.int_pos || ctl.int_reset) |-> ctl.bpf_bypass;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("filter not bypassed in float");
   property p_pos_float;
      ctl.int_pos |-> !ctl.pd_connect && !ctl.int_neg;
   endproperty
   a_pos_float: assert property (p_pos_float)
      else $error("positive phase with diode connected");
   property p_neg_first;
      $fell(ctl.int_pos) |-> ctl.int_neg && !ctl.pd_connect;
   endproperty
   a_neg_first: assert property (p_neg_first)
      else $error("negative phase not before reconnection");
   property p_dump;
      $rose(ctl.pd_connect) && $past(ctl.int_neg)
         |-> ctl.int_neg && ctl.tia_connect;
   endproperty
   a_dump: assert property (p_dump)
      else $error("charge dump outside negative phase");
   property p_tail;
      $fell(ctl.pd_connect) && ctl.int_neg |-> !ctl.tia_connect;
   endproperty
   a_tail: assert property (p_tail)
      else $error("receive path still connected after dump");
   property p_neg_end;
      $fell(ctl.int_neg) |-> adc_req && ctl.int_hold;
   endproperty
   a_neg_end: assert property (p_neg_end)
      else $error("no hold after negative phase");
   property p_hold;
      adc_req |-> ctl.int_hold && !ctl.int_neg && !ctl.int_pos;
   endproperty
   a_hold: assert property (p_hold)
      else $error("integrator moves while sampling");
   property p_err;
      cfg_err |-> !busy;
   endproperty
   a_err: assert property (p_err)
      else $error("refused slot runs");
   property p_done;
      slot_done |-> !busy ##1 !slot_done;
   endproperty
   a_done: assert property (p_done)
      else $error("slot end pulse malformed");
   property p_buf;
      res_valid && !res_ready |=> res_valid && $stable(res);
   endproperty
   a_buf: assert property (p_buf)
      else $error("result changed while stalled");
endmodule

/* File: dv/tb.sv */
/*
 Testbench of the float mode slot sequencer: float, ECG, refused and normal
 slots with a stalling reader.
 Assumes the design, sensor model and checker are compiled first.
*/
`timescale 1ns/1ps
module tb;
   logic              clk = 0;
   logic              rst_b = 0;
   logic              ecg_sync = 0;
   logic              slot_trig = 0;
   logic              res_ready = 0;
   logic              slow = 0;
   logic              adc_req, adc_valid, busy, slot_b_now, slot_done;
   logic              cfg_err, cfg_warn, res_valid;
   logic [19:0]       adc_data, slot_a_data, slot_b_data;
   fms_pkg::fms_cfg_t cfg_a, cfg_b;
   fms_pkg::fms_ctl_t ctl;
   fms_pkg::fms_res_t res;
   fms_pkg::fms_res_t got[$];
   int                runs[$];
   int                n_fail = 0, total_checks = 0;
   int                run = 0, n_pos = 0, led_f = 0, ecg_f = 0, i;
   int                n_cat = 0;
   logic              saw_pos = 0;

   always #2.5 clk = ~clk;

   fms_seq DUT (.clk(clk), .rst_b(rst_b), .cfg_a(cfg_a), .cfg_b(cfg_b),
      .ecg_sync(ecg_sync), .slot_trig(slot_trig), .adc_valid(adc_valid),
      .adc_data(adc_data), .adc_req(adc_req), .ctl(ctl), .busy(busy),
      .slot_b_now(slot_b_now), .slot_done(slot_done), .cfg_err(cfg_err),
      .cfg_warn(cfg_warn), .slot_a_data(slot_a_data),
      .slot_b_data(slot_b_data), .res_valid(res_valid),
      .res_ready(res_ready), .res(res));
   fms_sensor u_sen (.clk(clk), .rst_b(rst_b), .adc_req(adc_req),
      .slow(slow), .adc_valid(adc_valid), .adc_data(adc_data));

   ////////////////////////////////////////////////////////////////////////
   // Float window lengths, phase counts and drained words
   always @(posedge clk) begin
      if (busy && !ctl.pd_connect) run++;
      if (ctl.int_pos) begin
         n_pos++;
         saw_pos = 1;
      end
      if (ctl.pd_connect) begin
         if (saw_pos) runs.push_back(run);
         saw_pos = 0;
         run = 0;
      end
      if (ctl.cathode_bias) n_cat++;
      if (ctl.led_pulse && !ctl.pd_connect) led_f++;
      if (ctl.tia_adc_mode && ctl.external_current_input_one) ecg_f++;
      if (res_valid && res_ready) got.push_back(res);
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic fms_pkg::fms_cfg_t mk(logic [1:0] emit,
         logic [7:0] np, logic sync, logic [9:0] f1);
      fms_pkg::fms_cfg_t c;
      c = '0;
      c.slot_emitter_select = emit;
      c.slot_float_enable = 2'h3;
      c.slot_pulse_count = np;
      c.tia_reference_level = 2'h2;
      c.cathode_override = 1'b1;
      c.cathode_level = 2'h2;
      c.sync_led = sync;
      c.precon_us = 5'h01;
      c.float1_us = f1;
      c.float2_us = 10'h006;
      c.pos_us = 5'h01;
      c.negf_us = 5'h01;
      c.conn_us = 5'h01;
      c.tail_us = 5'h01;
      return c;
   endfunction

   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(logic [31:0] g, logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic trig;
      slot_trig = 1;
      cyc(1);
      slot_trig = 0;
   endtask

   task automatic wdone(int lim);
      for (i = 0; i < lim && slot_done !== 1'b1; i++) cyc(1);
      chk(slot_done, 1);
   endtask

   task automatic test_done;
      if (n_fail == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_float_a;
      fms_pkg::fms_cfg_t c;
      c = mk(2'h0, 8'h02, 1'b1, 10'h005);
      c.float2_us = 10'h00a;
      cfg_a = c;
      cyc(1);
      chk(cfg_warn, 0);
      chk(slot_b_now, 0);
      trig;
      chk(busy, 1);
      cyc(500);
      trig;
      wdone(6000);
      chk(runs.size(), 2);
      chk(runs[0], 1000);
      chk(runs[1], 2000);
      chk(runs[1], 2 * runs[0]);
      chk(n_pos, 400);
      chk(n_cat, 400);
      chk(led_f != 0, 1);
      chk(slot_a_data, 20'h0_a001);
      chk(slot_b_now, 1);
   endtask

   task automatic t_ecg_b;
      ecg_sync = 1;
      slow = 1;
      cfg_b = mk(2'h1, 8'h01, 1'b0, 10'h005);
      trig;
      for (i = 0; i < 2000 && adc_req !== 1'b1; i++) cyc(1);
      cyc(60);
      chk(adc_req, 1);
      chk(busy, 1);
      chk(ecg_f != 0, 1);
      res_ready = 1;
      wdone(300);
      cyc(4);
      chk(got.size(), 3);
      chk(got[0], {1'b0, 8'h00, 20'h0_a000});
      chk(got[1], {1'b0, 8'h01, 20'h0_a001});
      chk(got[2], {1'b1, 8'h00, 20'h0_a002});
      chk(slot_b_data, 20'h0_a002);
   endtask

   task automatic t_short;
      ecg_sync = 0;
      cfg_a = mk(2'h0, 8'h03, 1'b0, 10'h005);
      cyc(1);
      chk(cfg_warn, 1);
      cfg_a = mk(2'h0, 8'h02, 1'b0, 10'h003);
      trig;
      chk(busy, 0);
      wdone(4);
      chk(cfg_err, 1);
      chk(slot_b_now, 1);
   endtask

   task automatic t_normal;
      slow = 0;
      cfg_b = mk(2'h1, 8'h01, 1'b1, 10'h005);
      cyc(1);
      trig;
      chk(cfg_err, 0);
      wdone(3000);
      cyc(3);
      chk(n_pos, 400);
      chk(got.size(), 4);
      chk(got[3], {1'b1, 8'h00, 20'h0_a003});
   endtask

   initial begin
      cfg_a = mk(2'h0, 8'h02, 1'b1, 10'h005);
      cfg_b = mk(2'h1, 8'h01, 1'b0, 10'h005);
      cyc(10);
      rst_b = 1;
      t_float_a;
      t_ecg_b;
      t_short;
      t_normal;
      test_done;
   end

   initial begin
      #400000;
      n_fail++;
      test_done;
   end
endmodule

bind fms_seq fms_seq_chk u_chk (.clk(clk), .rst_b(rst_b), .ctl(ctl),
   .busy(busy), .adc_req(adc_req), .slot_done(slot_done),
   .cfg_err(cfg_err), .res_valid(res_valid), .res_ready(res_ready),
   .res(res));
